/* rtl/osc_ctrl_pkg.sv */
// Constants shared by the oscillator control block and its helpers.
// Assumes register indices are mapped to byte address index*4 on APB.
package osc_ctrl_pkg;
   // -----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // -----------------------------------------------------------------
   localparam logic [5:0] IDX_MAIN_SEL  = 6'h00;
   localparam logic [5:0] IDX_MAIN_STAT = 6'h03;
   localparam logic [5:0] IDX_FAST_CTRL = 6'h10;
   localparam logic [5:0] IDX_FREQ_TRIM = 6'h11;
   localparam logic [5:0] IDX_TEMP_TRIM = 6'h12;
   localparam logic [5:0] IDX_SLOW_CTRL = 6'h18;
   localparam logic [5:0] IDX_XTAL_CTRL = 6'h1C;
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int BIT_RUN_STDBY = 1;
   localparam int BIT_XTAL_EN   = 0;
   localparam int BIT_XTAL_SEL  = 2;
   localparam int CRYSTAL_STARTUP_COUNT_LSB      = 4;
   localparam int CRYSTAL_STARTUP_COUNT_MSB      = 5;
   localparam int BIT_TRIM_LOCK = 7;
   localparam int FREQ_TRIM_MSB = 5;
   localparam int TEMP_TRIM_MSB = 3;
   localparam int STAT_SWITCH   = 0;
   localparam int STAT_FAST     = 4;
   localparam int STAT_SLOW     = 5;
   localparam int STAT_XTAL     = 6;
   localparam int STAT_EXT      = 7;
   // -----------------------------------------------------------------
   // Sources, counts and factory trim values
   // -----------------------------------------------------------------
   localparam logic [1:0] SRC_FAST = 2'h0;
   localparam logic [1:0] SRC_SLOW = 2'h1;
   localparam logic [1:0] SRC_XTAL = 2'h2;
   localparam logic [1:0] SRC_EXT  = 2'h3;
   localparam int          CNT_W         = 17;
   localparam logic [2:0]  FAST_GATE_CYC = 3'h4;
   localparam logic [2:0]  XTAL_GATE_CYC = 3'h3;
   localparam logic [1:0]  FREQUENCY_SELECT_FUSE_BITS_16M   = 2'h1;
   localparam logic [5:0]  FREQ_TRIM_16M = 6'h1C;
   localparam logic [5:0]  FREQ_TRIM_20M = 6'h20;
   localparam logic [3:0]  TEMP_TRIM_16M = 4'h7;
   localparam logic [3:0]  TEMP_TRIM_20M = 4'h8;
   localparam logic [7:0]  RST_CTRL      = 8'h00;

   function automatic logic [3:0] src_onehot(input logic [1:0] src);
      src_onehot = 4'h1 << src;
   endfunction : src_onehot
endpackage : osc_ctrl_pkg

/* rtl/osc_gate_channel.sv */
// One oscillator: start-up tracking and request-driven output gate.
// Assumes tick_i is a one-cycle pulse per oscillator cycle, on CLK_I.
`timescale 1ns/10ps
module osc_gate_channel (
   input  wire logic                            clk,
   input  wire logic                            rst,
   input  wire logic                            tick_i,
   input  wire logic                            enable_i,
   input  wire logic                            force_i,
   input  wire logic                            req_i,
   input  wire logic [osc_ctrl_pkg::CNT_W-1:0]  startup_i,
   input  wire logic [2:0]                      gate_cyc_i,
   output logic                                 on_o,
   output logic                                 ready_o,
   output logic                                 gate_o
);
   typedef enum logic [2:0] {
      OFF = 3'b001, START = 3'b010, STABLE = 3'b100
   } osc_state_t;
   osc_state_t                      state;
   logic [osc_ctrl_pkg::CNT_W-1:0]  su_cnt;
   logic [2:0]                      g_cnt;
   logic                            run;

   assign run = enable_i && (force_i || req_i);

   // Every legal state is out of OFF after an edge exactly when run was high
   always_ff @(posedge clk) begin
      if (rst)
         on_o <= 1'b0;
      else
         on_o <= run;
   end

   // Forced-on oscillators stay STABLE, so a request sees only the gate
   always_ff @(posedge clk) begin
      if (rst) begin
         state  <= OFF;
         su_cnt <= '0;
      end else begin
         case (state)
            OFF: begin
               su_cnt <= '0;
               if (run)
                  state <= (startup_i == '0) ? STABLE : START;
            end
            START: begin
               if (!run)
                  state <= OFF;
               else if (tick_i) begin
                  su_cnt <= su_cnt + 1'b1;
                  if (su_cnt + 1'b1 >= startup_i)
                     state <= STABLE;
               end
            end
            STABLE: if (!run) state <= OFF;
            default: state <= OFF;
         endcase
      end
   end

   // Gate opens after gate_cyc_i oscillator cycles of a held request
   always_ff @(posedge clk) begin
      if (rst || !req_i || state != STABLE) begin
         g_cnt  <= '0;
         gate_o <= 1'b0;
      end else if (tick_i && !gate_o) begin
         g_cnt <= g_cnt + 1'b1;
         if (g_cnt + 1'b1 == gate_cyc_i)
            gate_o <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst)
         ready_o <= 1'b0;
      else
         ready_o <= (state == STABLE) && req_i;
   end

   chk_gate_req: assert property (@(posedge clk) disable iff (rst)
      gate_o |-> $past(req_i))
      else $error("gate open without request");
   chk_gate_delay: assert property (@(posedge clk) disable iff (rst)
      $rose(gate_o) |-> $past(g_cnt) + 3'h1 == $past(gate_cyc_i))
      else $error("gate opened after wrong cycle count");
   chk_forced_on: assert property (@(posedge clk) disable iff (rst)
      enable_i && force_i && $past(enable_i && force_i) |-> on_o)
      else $error("forced oscillator not running");
   chk_skip_start: assert property (@(posedge clk) disable iff (rst)
      state == OFF && run && startup_i == '0 |=> state == STABLE)
      else $error("start-up not skipped");
   cov_gate_open: cover property (@(posedge clk) disable iff (rst)
      $rose(gate_o));
endmodule : osc_gate_channel

/* rtl/main_clock_switch.sv */
// Main clock source tracker: follows the selected source once stable.
// Assumes stable_i holds one stable flag per source code.
`timescale 1ns/10ps
module main_clock_switch (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [1:0]  sel_i,
   input  wire logic [3:0]  stable_i,
   output logic [1:0]       cur_o,
   output logic             switching_o
);
   always_ff @(posedge clk) begin
      if (rst) begin
         cur_o       <= osc_ctrl_pkg::SRC_FAST;
         switching_o <= 1'b0;
      end else if (sel_i != cur_o && stable_i[sel_i]) begin
         cur_o       <= sel_i;
         switching_o <= 1'b0;
      end else begin
         switching_o <= (sel_i != cur_o);
      end
   end

   chk_switch_hold: assert property (@(posedge clk) disable iff (rst)
      sel_i != cur_o && !stable_i[sel_i] |=> switching_o && cur_o == $past(cur_o))
      else $error("main clock changed before source stable");
   cov_switch_done: cover property (@(posedge clk) disable iff (rst)
      $fell(switching_o));
endmodule : main_clock_switch

/* rtl/osc_ctrl.sv */
// Oscillator control and status registers on an APB slave port.
// Assumes oscillator tick inputs are one-cycle pulses on CLK_I and that
// fuse inputs are stable around reset.
//
// Summary of operation
// - Switching flag reads 1 until the newly selected source is stable.
// - Fast/slow run-in-standby keeps the oscillator running always.
// - Internal oscillator output only while that clock is requested.
// - Gate opens 4 oscillator cycles after request; forced-on skips start-up.
// - Six-bit frequency trim field shifts fast oscillator frequency.
// - Reset loads factory trims chosen by the frequency-select fuse bits.
// - Four-bit field sets fast oscillator temperature slope.
// - Read-only lock bit blocks writes to both trim registers.
// - Lock reset value comes from the trim-lock fuse bit.
// - Crystal select and start-up fields frozen while enabled or stable.
// - Start-up field selects 1k, 16k, 32k or 64k crystal cycles.
// - External clock source skips the crystal start-up count.
// - Select bit: 0 crystal, 1 external clock on crystal pin one.
// - Crystal run-in-standby with enable keeps crystal on always.
// - Crystal output passed on only while some peripheral requests it.
// - Forced-on, started crystal delivers output two to three cycles after request.
// - Crystal enable takes over both pins and freezes select/start-up.
// - Crystal stable status reads 1 only when stable and requested.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
module osc_ctrl #(
   parameter int unsigned XTAL_SU_0 = 1024,
   parameter int unsigned XTAL_SU_1 = 16384,
   parameter int unsigned XTAL_SU_2 = 32768,
   parameter int unsigned XTAL_SU_3 = 65536,
   parameter int unsigned FAST_SU   = 16,
   parameter int unsigned SLOW_SU   = 16
) (
   input  wire logic         CLK_I,
   input  wire logic         RESET_I,
   input  wire logic         PSEL_I,
   input  wire logic         PENABLE_I,
   input  wire logic         PWRITE_I,
   input  wire logic [7:0]   PADDR_I,
   input  wire logic [31:0]  PWDATA_I,
   input  wire logic [1:0]   FUSE_FREQ_SEL_I,
   input  wire logic         FUSE_TRIM_LOCK_I,
   input  wire logic         PROT_WRITE_OK_I,
   input  wire logic         FAST_TICK_I,
   input  wire logic         SLOW_TICK_I,
   input  wire logic         XTAL_TICK_I,
   input  wire logic         EXT_CLK_OK_I,
   input  wire logic         FAST_REQ_I,
   input  wire logic         SLOW_REQ_I,
   input  wire logic         XTAL_REQ_I,
   output logic [31:0]       PRDATA_O,
   output logic              PREADY_O,
   output logic              PSLVERR_O,
   output logic              FAST_OSC_ON_O,
   output logic              SLOW_OSC_ON_O,
   output logic              XTAL_OSC_ON_O,
   output logic              FAST_CLK_GATE_O,
   output logic              SLOW_CLK_GATE_O,
   output logic              XTAL_CLK_GATE_O,
   output logic [5:0]        FREQ_TRIM_O,
   output logic [3:0]        TEMP_SLOPE_O,
   output logic              XTAL_PIN_OVR_O,
   output logic              XTAL_EXT_CLK_O,
   output logic [1:0]        MAIN_CLK_SRC_O
);
   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [1:0]                      main_sel;
   logic                            fast_rs;
   logic                            slow_rs;
   logic [5:0]                      freq_trim;
   logic [3:0]                      temp_trim;
   logic                            trim_lock;
   logic [1:0]                      xtal_crystal_startup_count;
   logic                            xtal_sel;
   logic                            xtal_rs;
   logic                            xtal_en;
   logic                            init_done;
   logic [1:0]                      cur_src;
   logic                            switching;
   logic                            fast_ready;
   logic                            slow_ready;
   logic                            xtal_ready;
   logic [3:0]                      main_req;
   logic [osc_ctrl_pkg::CNT_W-1:0]  xtal_su;
   logic [osc_ctrl_pkg::CNT_W-1:0]  fast_su;
   logic [osc_ctrl_pkg::CNT_W-1:0]  slow_su;
   logic [5:0]                      idx;
   logic                            acc;
   logic                            wr;
   logic                            mapped;
   logic [7:0]                      next_rdata;
   logic [7:0]                      wd;

   assign idx = PADDR_I[7:2];
   assign wd  = PWDATA_I[7:0];
   assign acc = PSEL_I && PENABLE_I && !PREADY_O;
   // Write lands on the edge where the master sees pready high
   assign wr  = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && mapped;

   always_comb begin
      case (idx)
         osc_ctrl_pkg::IDX_MAIN_SEL,  osc_ctrl_pkg::IDX_MAIN_STAT,
         osc_ctrl_pkg::IDX_FAST_CTRL, osc_ctrl_pkg::IDX_FREQ_TRIM,
         osc_ctrl_pkg::IDX_TEMP_TRIM, osc_ctrl_pkg::IDX_SLOW_CTRL,
         osc_ctrl_pkg::IDX_XTAL_CTRL: mapped = (PADDR_I[1:0] == 2'h0);
         default:                     mapped = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Oscillator control writes
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         main_sel <= osc_ctrl_pkg::SRC_FAST;
         fast_rs  <= 1'b0;
         slow_rs  <= 1'b0;
      end else if (wr) begin
         case (idx)
            osc_ctrl_pkg::IDX_MAIN_SEL:  main_sel <= wd[1:0];
            osc_ctrl_pkg::IDX_FAST_CTRL:
               fast_rs <= wd[osc_ctrl_pkg::BIT_RUN_STDBY];
            osc_ctrl_pkg::IDX_SLOW_CTRL:
               slow_rs <= wd[osc_ctrl_pkg::BIT_RUN_STDBY];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Fast oscillator trim, loaded from fuses during reset
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         trim_lock <= FUSE_TRIM_LOCK_I;
         if (FUSE_FREQ_SEL_I == osc_ctrl_pkg::FREQUENCY_SELECT_FUSE_BITS_16M) begin
            freq_trim <= osc_ctrl_pkg::FREQ_TRIM_16M;
            temp_trim <= osc_ctrl_pkg::TEMP_TRIM_16M;
         end else begin
            freq_trim <= osc_ctrl_pkg::FREQ_TRIM_20M;
            temp_trim <= osc_ctrl_pkg::TEMP_TRIM_20M;
         end
      end else if (wr && !trim_lock) begin
         if (idx == osc_ctrl_pkg::IDX_FREQ_TRIM)
            freq_trim <= wd[osc_ctrl_pkg::FREQ_TRIM_MSB:0];
         if (idx == osc_ctrl_pkg::IDX_TEMP_TRIM)
            temp_trim <= wd[osc_ctrl_pkg::TEMP_TRIM_MSB:0];
      end
   end

   // ----------------------------------------------------------------
   // Crystal control
   // ----------------------------------------------------------------
   // Select and start-up freeze on the old enable, so a write that sets
   // enable may still load them in the same access.
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         xtal_crystal_startup_count <= '0;
         xtal_sel  <= 1'b0;
         xtal_rs   <= 1'b0;
         xtal_en   <= 1'b0;
      end else if (wr && idx == osc_ctrl_pkg::IDX_XTAL_CTRL) begin
         if (!xtal_en && !xtal_ready) begin
            xtal_crystal_startup_count <= wd[osc_ctrl_pkg::CRYSTAL_STARTUP_COUNT_MSB:osc_ctrl_pkg::CRYSTAL_STARTUP_COUNT_LSB];
            xtal_sel  <= wd[osc_ctrl_pkg::BIT_XTAL_SEL];
         end
         if (PROT_WRITE_OK_I) begin
            xtal_rs <= wd[osc_ctrl_pkg::BIT_RUN_STDBY];
            xtal_en <= wd[osc_ctrl_pkg::BIT_XTAL_EN];
         end
      end
   end

   always_comb begin
      case (xtal_crystal_startup_count)
         2'h0:    xtal_su = osc_ctrl_pkg::CNT_W'(XTAL_SU_0);
         2'h1:    xtal_su = osc_ctrl_pkg::CNT_W'(XTAL_SU_1);
         2'h2:    xtal_su = osc_ctrl_pkg::CNT_W'(XTAL_SU_2);
         default: xtal_su = osc_ctrl_pkg::CNT_W'(XTAL_SU_3);
      endcase
      if (xtal_sel)
         xtal_su = '0;
   end

   // Start-up applies only from cold; a forced-on oscillator is already up
   assign fast_su = osc_ctrl_pkg::CNT_W'(FAST_SU);
   assign slow_su = osc_ctrl_pkg::CNT_W'(SLOW_SU);

   // The main clock counts as a requester of both old and new source
   assign main_req = osc_ctrl_pkg::src_onehot(main_sel)
                   | osc_ctrl_pkg::src_onehot(cur_src);

   // ----------------------------------------------------------------
   // Oscillator channels and main source switch
   // ----------------------------------------------------------------
   osc_gate_channel u_fast (
      .clk        (CLK_I),
      .rst        (RESET_I),
      .tick_i     (FAST_TICK_I),
      .enable_i   (1'b1),
      .force_i    (fast_rs),
      .req_i      (FAST_REQ_I || main_req[osc_ctrl_pkg::SRC_FAST]),
      .startup_i  (fast_su),
      .gate_cyc_i (osc_ctrl_pkg::FAST_GATE_CYC),
      .on_o       (FAST_OSC_ON_O),
      .ready_o    (fast_ready),
      .gate_o     (FAST_CLK_GATE_O)
   );

   osc_gate_channel u_slow (
      .clk        (CLK_I),
      .rst        (RESET_I),
      .tick_i     (SLOW_TICK_I),
      .enable_i   (1'b1),
      .force_i    (slow_rs),
      .req_i      (SLOW_REQ_I || main_req[osc_ctrl_pkg::SRC_SLOW]),
      .startup_i  (slow_su),
      .gate_cyc_i (osc_ctrl_pkg::FAST_GATE_CYC),
      .on_o       (SLOW_OSC_ON_O),
      .ready_o    (slow_ready),
      .gate_o     (SLOW_CLK_GATE_O)
   );

   osc_gate_channel u_xtal (
      .clk        (CLK_I),
      .rst        (RESET_I),
      .tick_i     (XTAL_TICK_I),
      .enable_i   (xtal_en),
      .force_i    (xtal_rs),
      .req_i      (XTAL_REQ_I || main_req[osc_ctrl_pkg::SRC_XTAL]),
      .startup_i  (xtal_su),
      .gate_cyc_i (osc_ctrl_pkg::XTAL_GATE_CYC),
      .on_o       (XTAL_OSC_ON_O),
      .ready_o    (xtal_ready),
      .gate_o     (XTAL_CLK_GATE_O)
   );

   main_clock_switch u_switch (
      .clk         (CLK_I),
      .rst         (RESET_I),
      .sel_i       (main_sel),
      .stable_i    ({EXT_CLK_OK_I, xtal_ready, slow_ready, fast_ready}),
      .cur_o       (cur_src),
      .switching_o (switching)
   );

   // ----------------------------------------------------------------
   // Pin and trim outputs
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         XTAL_PIN_OVR_O <= 1'b0;
         XTAL_EXT_CLK_O <= 1'b0;
         FREQ_TRIM_O    <= '0;
         TEMP_SLOPE_O   <= '0;
         MAIN_CLK_SRC_O <= osc_ctrl_pkg::SRC_FAST;
      end else begin
         XTAL_PIN_OVR_O <= xtal_en;
         XTAL_EXT_CLK_O <= xtal_sel;
         FREQ_TRIM_O    <= freq_trim;
         TEMP_SLOPE_O   <= temp_trim;
         MAIN_CLK_SRC_O <= cur_src;
      end
   end

   // ----------------------------------------------------------------
   // APB read path, one wait state
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata = osc_ctrl_pkg::RST_CTRL;
      case (idx)
         osc_ctrl_pkg::IDX_MAIN_SEL:  next_rdata[1:0] = main_sel;
         osc_ctrl_pkg::IDX_MAIN_STAT: begin
            next_rdata[osc_ctrl_pkg::STAT_SWITCH] = switching;
            next_rdata[osc_ctrl_pkg::STAT_FAST]   = fast_ready;
            next_rdata[osc_ctrl_pkg::STAT_SLOW]   = slow_ready;
            next_rdata[osc_ctrl_pkg::STAT_XTAL]   = xtal_ready;
            next_rdata[osc_ctrl_pkg::STAT_EXT]    = EXT_CLK_OK_I;
         end
         osc_ctrl_pkg::IDX_FAST_CTRL:
            next_rdata[osc_ctrl_pkg::BIT_RUN_STDBY] = fast_rs;
         osc_ctrl_pkg::IDX_FREQ_TRIM:
            next_rdata[osc_ctrl_pkg::FREQ_TRIM_MSB:0] = freq_trim;
         osc_ctrl_pkg::IDX_TEMP_TRIM: begin
            next_rdata[osc_ctrl_pkg::TEMP_TRIM_MSB:0] = temp_trim;
            next_rdata[osc_ctrl_pkg::BIT_TRIM_LOCK]   = trim_lock;
         end
         osc_ctrl_pkg::IDX_SLOW_CTRL:
            next_rdata[osc_ctrl_pkg::BIT_RUN_STDBY] = slow_rs;
         osc_ctrl_pkg::IDX_XTAL_CTRL: begin
            next_rdata[osc_ctrl_pkg::CRYSTAL_STARTUP_COUNT_MSB:osc_ctrl_pkg::CRYSTAL_STARTUP_COUNT_LSB] =
               xtal_crystal_startup_count;
            next_rdata[osc_ctrl_pkg::BIT_XTAL_SEL]  = xtal_sel;
            next_rdata[osc_ctrl_pkg::BIT_RUN_STDBY] = xtal_rs;
            next_rdata[osc_ctrl_pkg::BIT_XTAL_EN]   = xtal_en;
         end
         default: ;
      endcase
      if (!mapped)
         next_rdata = '0;
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= '0;
      end else begin
         PREADY_O  <= acc;
         PSLVERR_O <= acc && !mapped;
         if (acc)
            PRDATA_O <= {24'h000000, next_rdata};
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   chk_trim_lock: assert property (
      trim_lock && wr |=> freq_trim == $past(freq_trim)
                       && temp_trim == $past(temp_trim))
      else $error("locked trim changed");
   chk_trim_reset: assert property (disable iff (1'b0)
      $past(RESET_I) && !RESET_I
      && $past(FUSE_FREQ_SEL_I) == osc_ctrl_pkg::FREQUENCY_SELECT_FUSE_BITS_16M
      |-> freq_trim == osc_ctrl_pkg::FREQ_TRIM_16M)
      else $error("factory trim not loaded");
   chk_lock_fuse: assert property (disable iff (1'b0)
      $past(RESET_I) && !RESET_I |-> trim_lock == $past(FUSE_TRIM_LOCK_I))
      else $error("lock not taken from fuse");
   chk_xtal_frozen: assert property (
      wr && (xtal_en || xtal_ready) |=> xtal_sel == $past(xtal_sel)
                                     && xtal_crystal_startup_count == $past(xtal_crystal_startup_count))
      else $error("crystal setup changed while enabled");
   chk_prot_write: assert property (
      !PROT_WRITE_OK_I |=> xtal_en == $past(xtal_en))
      else $error("unprotected enable write");
   chk_reserved: assert property (
      PREADY_O |-> PRDATA_O[31:8] == 24'h000000)
      else $error("reserved read bits set");
   chk_apb_wait: assert property (
      acc |=> PREADY_O ##1 !PREADY_O || PSEL_I)
      else $error("bus answer late");
   cov_xtal_stable: cover property ($rose(xtal_ready));
   cov_locked_write: cover property (trim_lock && wr);
endmodule : osc_ctrl

/* sim/osc_partner_model.sv */
// Oscillator model: one tick pulse per cycle while each one runs.
// Assumes the bench clock only; ticks last one clock cycle.
`timescale 1ns/10ps
module osc_partner_model (
   input  wire logic clk_i,
   input  wire logic fast_on_i,
   input  wire logic slow_on_i,
   input  wire logic xtal_on_i,
   output logic      fast_tick_o,
   output logic      slow_tick_o,
   output logic      xtal_tick_o,
   output logic      ext_ok_o
);
   logic [2:0] phase = 3'h0;
   always_ff @(posedge clk_i) phase <= phase + 3'h1;
   // A stopped oscillator gives no edges, so counts stall with it
   assign fast_tick_o = fast_on_i & phase[0];
   assign slow_tick_o = slow_on_i & (phase[1:0] == 2'h3);
   assign xtal_tick_o = xtal_on_i & (phase == 3'h7);
   assign ext_ok_o    = xtal_on_i;
endmodule : osc_partner_model

/* sim/oscillator_control_regs_tb_top.sv */
// Bench for the oscillator control registers over APB.
// Assumes the oscillator model in osc_partner_model.
`timescale 1ns/10ps
module oscillator_control_regs_tb_top;
   logic CLK_I = 1'h0, RESET_I = 1'h1, PSEL_I = 1'h0, PENABLE_I = 1'h0;
   logic PWRITE_I = 1'h0, PROT_WRITE_OK_I = 1'h0, er;
   logic FUSE_TRIM_LOCK_I = 1'h0, FAST_REQ_I = 1'h0;
   logic SLOW_REQ_I = 1'h0, XTAL_REQ_I = 1'h0;
   logic [7:0] PADDR_I = 8'h00, v;
   logic [31:0] PWDATA_I = 32'h0, PRDATA_O, rd;
   logic [1:0] FUSE_FREQ_SEL_I = 2'h1, MAIN_CLK_SRC_O;
   logic PREADY_O, PSLVERR_O, FAST_OSC_ON_O, SLOW_OSC_ON_O;
   logic XTAL_OSC_ON_O, FAST_CLK_GATE_O, SLOW_CLK_GATE_O;
   logic XTAL_CLK_GATE_O, XTAL_PIN_OVR_O, XTAL_EXT_CLK_O;
   logic FAST_TICK_I, SLOW_TICK_I, XTAL_TICK_I, EXT_CLK_OK_I;
   logic [5:0] FREQ_TRIM_O, ef;
   logic [3:0] TEMP_SLOPE_O, et;
   int mismatches = 0, total_checks = 0, n;
   always #25 CLK_I = ~CLK_I;
   osc_partner_model partner (.clk_i(CLK_I), .fast_on_i(FAST_OSC_ON_O),
      .slow_on_i(SLOW_OSC_ON_O), .xtal_on_i(XTAL_OSC_ON_O),
      .fast_tick_o(FAST_TICK_I), .slow_tick_o(SLOW_TICK_I),
      .xtal_tick_o(XTAL_TICK_I), .ext_ok_o(EXT_CLK_OK_I));
   // Short start-up counts keep the crystal paths inside the run
   osc_ctrl #(.XTAL_SU_0(4), .XTAL_SU_1(8), .XTAL_SU_2(12),
      .XTAL_SU_3(16), .SLOW_SU(2)) uut (.*);
   task automatic report_and_stop();
      if (mismatches == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [31:0] s, e);
      total_checks++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic step(inout int k);
      @(posedge CLK_I);
      k++;
      if (k > 200) begin
         mismatches++;
         report_and_stop();
      end
   endtask : step
   function automatic logic sig(input int i);
      logic [4:0] s;
      s = {FAST_CLK_GATE_O, MAIN_CLK_SRC_O === 2'h1, XTAL_CLK_GATE_O,
           SLOW_CLK_GATE_O, SLOW_OSC_ON_O};
      return s[i];
   endfunction : sig
   task automatic wt(input int i);
      n = 0;
      while (sig(i) !== 1'h1) step(n);
   endtask : wt
   task automatic apb(input logic w, input logic [5:0] ix,
                      input logic [7:0] d);
      int k;
      k = 0;
      @(posedge CLK_I);
      PSEL_I <= 1'h1;
      PWRITE_I <= w;
      PADDR_I <= {ix, 2'h0};
      PWDATA_I <= {24'h0, d};
      @(posedge CLK_I);
      PENABLE_I <= 1'h1;
      do step(k); while (PREADY_O !== 1'h1);
      rd = PRDATA_O;
      er = PSLVERR_O;
      PSEL_I <= 1'h0;
      PENABLE_I <= 1'h0;
   endtask : apb
   initial begin
      void'($urandom(32'hA461B940));
      for (int p = 0; p < 2; p++) begin
         RESET_I <= 1'h1;
         FUSE_FREQ_SEL_I <= 2'(1 - p);
         FUSE_TRIM_LOCK_I <= 1'(p);
         repeat (5) @(posedge CLK_I);
         RESET_I <= 1'h0;
         @(posedge CLK_I);
         ef = p ? osc_ctrl_pkg::FREQ_TRIM_20M : osc_ctrl_pkg::FREQ_TRIM_16M;
         et = p ? osc_ctrl_pkg::TEMP_TRIM_20M : osc_ctrl_pkg::TEMP_TRIM_16M;
         apb(0, osc_ctrl_pkg::IDX_FREQ_TRIM, 8'h00);
         chk("freq trim reset", rd, ef);
         apb(0, osc_ctrl_pkg::IDX_TEMP_TRIM, 8'h00);
         chk("temp trim reset", rd, {FUSE_TRIM_LOCK_I, 3'h0, et});
         v = 8'($urandom);
         apb(1, osc_ctrl_pkg::IDX_FREQ_TRIM, v);
         apb(1, osc_ctrl_pkg::IDX_TEMP_TRIM, v);
         ef = p ? ef : v[5:0];
         et = p ? et : v[3:0];
         apb(0, osc_ctrl_pkg::IDX_FREQ_TRIM, 8'h00);
         chk("freq trim", rd, ef);
         apb(0, osc_ctrl_pkg::IDX_TEMP_TRIM, 8'h00);
         chk("temp trim", rd, {FUSE_TRIM_LOCK_I, 3'h0, et});
         chk("freq out", FREQ_TRIM_O, ef);
         chk("slope out", TEMP_SLOPE_O, et);
      end
      apb(1, osc_ctrl_pkg::IDX_SLOW_CTRL, 8'hFF);
      apb(1, osc_ctrl_pkg::IDX_FAST_CTRL, 8'hFF);
      apb(0, osc_ctrl_pkg::IDX_FAST_CTRL, 8'h00);
      chk("fast ctrl", rd, 32'h02);
      wt(0);
      repeat (8) @(posedge CLK_I);
      chk("idle gate", SLOW_CLK_GATE_O, 1'h0);
      SLOW_REQ_I <= 1'h1;
      wt(1);
      chk("gate delay", n >= 14 && n <= 17, 1'h1);
      SLOW_REQ_I <= 1'h0;
      apb(1, osc_ctrl_pkg::IDX_XTAL_CTRL, 8'hFF);
      apb(0, osc_ctrl_pkg::IDX_XTAL_CTRL, 8'h00);
      chk("xtal unprotected", rd, 32'h34);
      chk("gate closed", SLOW_CLK_GATE_O, 1'h0);
      PROT_WRITE_OK_I <= 1'h1;
      apb(1, osc_ctrl_pkg::IDX_XTAL_CTRL, 8'h37);
      apb(1, osc_ctrl_pkg::IDX_XTAL_CTRL, 8'h03);
      apb(0, osc_ctrl_pkg::IDX_XTAL_CTRL, 8'h00);
      chk("xtal frozen", rd, 32'h37);
      chk("pins", {XTAL_PIN_OVR_O, XTAL_EXT_CLK_O}, 2'h3);
      XTAL_REQ_I <= 1'h1;
      wt(2);
      chk("ext start", n >= 18 && n <= 25, 1'h1);
      apb(1, osc_ctrl_pkg::IDX_MAIN_SEL, 8'h01);
      wt(3);
      apb(0, osc_ctrl_pkg::IDX_MAIN_STAT, 8'h00);
      chk("main status", {rd[5], rd[0]}, 2'h2);
      chk("fast forced", {FAST_OSC_ON_O, FAST_CLK_GATE_O}, 2'h2);
      FAST_REQ_I <= 1'h1;
      wt(4);
      chk("fast gate delay", n >= 8 && n <= 9, 1'h1);
      FAST_REQ_I <= 1'h0;
      apb(0, 6'h05, 8'h00);
      chk("unmapped", er, 1'h1);
      XTAL_REQ_I <= 1'h0;
      apb(1, osc_ctrl_pkg::IDX_XTAL_CTRL, 8'h00);
      n = 0;
      do begin
         apb(0, osc_ctrl_pkg::IDX_MAIN_STAT, 8'h00);
         step(n);
      end while (rd[6] !== 1'h0);
      apb(1, osc_ctrl_pkg::IDX_XTAL_CTRL, 8'h01);
      apb(0, osc_ctrl_pkg::IDX_XTAL_CTRL, 8'h00);
      chk("xtal reconfig", rd, 32'h01);
      chk("pin one", {XTAL_PIN_OVR_O, XTAL_EXT_CLK_O}, 2'h2);
      chk("xtal idle", XTAL_OSC_ON_O, 1'h0);
      XTAL_REQ_I <= 1'h1;
      wt(2);
      chk("xtal start-up", n >= 51 && n <= 58, 1'h1);
      report_and_stop();
   end
endmodule : oscillator_control_regs_tb_top
